// File: rtl/php_host_port.sv
// host register port and pixel path of the colour palette
// assumes strobes, select and data arrive asynchronously from the host
`timescale 1ns/10ps
// Function
// - 15-bit direct colour byte to DAC mapping
// - 16-bit direct colour byte to DAC mapping
// - 24-bit direct colour passes bytes bit for bit
// - stolen video cycle repeats previous pixel colour
// - sleep plus inhibit: only mode register and id reachable
// - byte registers one cycle, colour three cycles
// - select on write fall, data on rise
// - third colour byte stores entry, index increments
// - read select on fall, drive until after rise
// - read index write fetches entry, increments, refetches
// - register bit n on data line n
// - table address is pixel AND mask
// - mask access synchronised to pixel clock
// - colour fields on lines 5..0, red first
// - select code 6 reaches mode register directly
// - fourth mask read gives id, then mode
// - mode stays unlocked after read, write relocks
// - other access restarts key; top line low ok
// - read-only identification byte, mixed ones and zeros
// - mode register field layout, zero means off
// - table lookup at reset and when disabled
// - table access steals only one video cycle
// - inhibit stops clocking and table, mode reachable
module php_host_port
    import php_pkg::*;
#(
    parameter logic [7:0] ID_VALUE = 8'h5A  // arbitrary identification value
) (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    // host port
    input  wire logic [2:0] register_select_i,
    input  wire logic       write_strobe_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic [7:0] host_data_bus_i,
    output logic      [7:0] host_data_bus_o,
    output logic            host_data_bus_oe_o,
    // video input
    input  wire logic [7:0] pixel_input_bus_i,
    input  wire logic       blank_n_i,
    // DAC inputs
    output logic      [7:0] dac_red_o,
    output logic      [7:0] dac_green_o,
    output logic      [7:0] dac_blue_o,
    // mode outputs
    output logic            sleep_o,
    output logic            clock_inhibit_o,
    output logic      [2:0] sync_enable_o
);
    import php_pkg::*;

    if (ID_VALUE == 8'h00 || ID_VALUE == 8'hFF) begin : g_bad_id
        $error("identification value must hold both ones and zeros");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0]          wr_sync;
        logic [2:0]          rd_sync;
        logic [2:0][2:0]     sel_sync;
        logic [2:0][7:0]     dat_sync;
        logic                wr_lvl;
        logic                rd_lvl;
        logic [2:0]          sel;
        logic [7:0]          index;
        logic [1:0]          wcnt;
        logic [1:0]          rcnt;
        logic [11:0]         wbuf;
        logic [17:0]         wdata;
        logic [17:0]         rval;
        logic                wr_req;
        logic                rd_req;
        logic                rd_wait;
        logic [7:0]          mask;
        logic [7:0]          mode;
        logic [1:0]          key_cnt;
        logic                unlocked;
        logic [7:0]          dout;
        logic                oe;
        logic [7:0]          pix;
        logic                blank_n;
        php_phase_type       phase;
        logic [7:0]          byte0;
        logic [7:0]          byte1;
        logic                vid_rd;
        logic [7:0]          red;
        logic [7:0]          green;
        logic [7:0]          blue;
    } php_state_type;

    php_state_type q, d;

    logic [COLOUR_W-1:0] ram_rdata;
    logic [COLOUR_W-1:0] ram_wdata;
    logic [7:0]          ram_addr;
    logic                ram_we;

    php_colour_table #(
        .DEPTH  (256),
        .WIDTH  (COLOUR_W),
        .ADDR_W (8)
    ) i_php_colour_table (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .addr_i   (ram_addr),
        .we_i     (ram_we),
        .wdata_i  (ram_wdata),
        .rdata_o  (ram_rdata)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic       wr_fall;
        logic       wr_rise;
        logic       rd_fall;
        logic       rd_rise;
        logic       frozen;
        logic       inhibit;
        logic       host_op;
        logic       mode_wr;
        logic       is24;
        logic [2:0] sel_now;
        logic [7:0] dat_now;
        logic [7:0] b1;
        d         = q;
        ram_we    = 1'b0;
        ram_wdata = q.wdata;
        ram_addr  = q.pix & q.mask;
        host_op   = 1'b0;
        mode_wr   = 1'b0;
        is24      = q.mode[CMD_FMT_LSB+1];
        b1        = q.byte1;
        inhibit   = q.mode[CMD_INHIBIT_BIT];
        frozen    = inhibit & q.mode[CMD_SLEEP_BIT];

        // three stage synchronisers; stages two and three must agree
        d.wr_sync  = {q.wr_sync[1:0], write_strobe_n_i};
        d.rd_sync  = {q.rd_sync[1:0], read_strobe_n_i};
        d.sel_sync = {q.sel_sync[1:0], register_select_i};
        d.dat_sync = {q.dat_sync[1:0], host_data_bus_i};
        sel_now    = q.sel_sync[2];
        dat_now    = q.dat_sync[2];
        wr_fall    = (q.wr_sync[1] == q.wr_sync[2]) && q.wr_lvl && !q.wr_sync[2];
        wr_rise    = (q.wr_sync[1] == q.wr_sync[2]) && !q.wr_lvl && q.wr_sync[2];
        rd_fall    = (q.rd_sync[1] == q.rd_sync[2]) && q.rd_lvl && !q.rd_sync[2];
        rd_rise    = (q.rd_sync[1] == q.rd_sync[2]) && !q.rd_lvl && q.rd_sync[2];
        if (wr_fall || wr_rise) begin
            d.wr_lvl = q.wr_sync[2];
        end
        if (rd_fall || rd_rise) begin
            d.rd_lvl = q.rd_sync[2];
        end

        // ----------------------------------------
        // table port: one stolen video cycle per entry
        // ----------------------------------------
        if (q.rd_wait) begin
            d.rval    = ram_rdata;
            d.rd_wait = 1'b0;
        end
        if (!inhibit) begin
            if (q.wr_req) begin
                ram_we   = 1'b1;
                ram_addr = q.index;
                d.index  = q.index + 8'h01;
                d.wr_req = 1'b0;
                host_op  = 1'b1;
            end else if (q.rd_req) begin
                ram_addr  = q.index;
                d.index   = q.index + 8'h01;
                d.rd_req  = 1'b0;
                d.rd_wait = 1'b1;
                host_op   = 1'b1;
            end
        end

        // ----------------------------------------
        // host write: select at fall, data at rise
        // ----------------------------------------
        if (wr_fall) begin
            d.sel = sel_now;
        end
        if (wr_rise) begin
            mode_wr    = (q.sel == SEL_MODE) || (q.sel == SEL_MASK && q.unlocked);
            d.key_cnt  = 2'h0;
            d.unlocked = 1'b0;
            if (mode_wr) begin
                d.mode = dat_now;
            end else if (!frozen) begin
                unique case (q.sel)
                    SEL_WRITE_INDEX: begin
                        d.index = dat_now;
                        d.wcnt  = 2'h0;
                    end
                    SEL_READ_INDEX: begin
                        d.index  = dat_now;
                        d.rcnt   = 2'h0;
                        d.rd_req = !inhibit;
                    end
                    SEL_MASK: begin
                        d.mask = inhibit ? q.mask : dat_now;
                    end
                    SEL_COLOUR: begin
                        d.wbuf = {q.wbuf[FIELD_W-1:0], dat_now[FIELD_W-1:0]};
                        d.wcnt = q.wcnt + 2'h1;
                        if (q.wcnt == BYTE_LAST) begin
                            d.wdata  = {q.wbuf, dat_now[FIELD_W-1:0]};
                            d.wr_req = !inhibit;
                            d.wcnt   = 2'h0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // ----------------------------------------
        // host read: drive at fall, release after rise
        // ----------------------------------------
        if (rd_fall) begin
            d.sel  = sel_now;
            d.oe   = 1'b1;
            d.dout = 8'h00;
            if (sel_now == SEL_MODE) begin
                d.dout = q.mode;
            end else if (sel_now == SEL_MASK && q.unlocked) begin
                d.dout = q.mode;
            end else if (sel_now == SEL_MASK && q.key_cnt == KEY_LAST) begin
                d.dout = ID_VALUE;
            end else if (!frozen) begin
                unique case (sel_now)
                    SEL_WRITE_INDEX, SEL_READ_INDEX: d.dout = q.index;
                    SEL_MASK:                        d.dout = q.mask;
                    SEL_COLOUR: begin
                        unique case (q.rcnt)
                            2'h0:    d.dout = {2'h0, q.rval[17:12]};
                            2'h1:    d.dout = {2'h0, q.rval[11:6]};
                            default: d.dout = {2'h0, q.rval[5:0]};
                        endcase
                    end
                    default: d.dout = 8'h00;
                endcase
            end
        end
        if (rd_rise) begin
            d.oe = 1'b0;
            if (q.sel == SEL_MASK) begin
                if (!q.unlocked) begin
                    if (q.key_cnt == KEY_LAST) begin
                        d.unlocked = 1'b1;
                        d.key_cnt  = 2'h0;
                    end else begin
                        d.key_cnt = q.key_cnt + 2'h1;
                    end
                end
            end else begin
                d.key_cnt  = 2'h0;
                d.unlocked = 1'b0;
            end
            if (q.sel == SEL_COLOUR && !frozen) begin
                d.rcnt = q.rcnt + 2'h1;
                if (q.rcnt == BYTE_LAST) begin
                    d.rcnt   = 2'h0;
                    d.rd_req = !inhibit;
                end
            end
        end

        // ----------------------------------------
        // pixel path, frozen while clocking is inhibited
        // ----------------------------------------
        if (!inhibit) begin
            d.pix     = pixel_input_bus_i;
            d.blank_n = blank_n_i;
            d.vid_rd  = !host_op;
            if (!q.mode[CMD_DIRECT_BIT]) begin
                // a stolen cycle leaves the DAC inputs on the last colour
                if (q.vid_rd) begin
                    d.red   = {ram_rdata[17:12], 2'h0};
                    d.green = {ram_rdata[11:6], 2'h0};
                    d.blue  = {ram_rdata[5:0], 2'h0};
                end
            end else if (!q.blank_n) begin
                d.phase = PH_FIRST;
            end else begin
                unique case (q.phase)
                    PH_FIRST: begin
                        d.byte0 = q.pix;
                        d.phase = PH_SECOND;
                    end
                    PH_SECOND: begin
                        d.byte1 = q.pix;
                        b1      = q.pix;
                        d.phase = is24 ? PH_THIRD : PH_FIRST;
                    end
                    default: begin
                        d.phase = PH_FIRST;
                    end
                endcase
                if (q.phase == PH_THIRD) begin
                    d.red   = q.pix;
                    d.green = q.byte1;
                    d.blue  = q.byte0;
                end else if (q.phase == PH_SECOND && !is24) begin
                    d.blue = {q.byte0[4:0], 3'h0};
                    if (q.mode[CMD_FMT_LSB +: 2] == FMT_16) begin
                        d.red   = {b1[7:3], 3'h0};
                        d.green = {b1[2:0], q.byte0[7:5], 2'h0};
                    end else begin
                        d.red   = {b1[6:2], 3'h0};
                        d.green = {b1[1:0], q.byte0[7:5], 3'h0};
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q          <= '0;
            q.wr_sync  <= 3'h7;
            q.rd_sync  <= 3'h7;
            q.wr_lvl   <= 1'b1;
            q.rd_lvl   <= 1'b1;
            q.mask     <= MASK_RESET;
            q.index    <= INDEX_RESET;
            q.mode     <= CMD_RESET;
            q.phase    <= PH_FIRST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign host_data_bus_o    = q.dout;
    assign host_data_bus_oe_o = q.oe;
    assign dac_red_o          = q.red;
    assign dac_green_o        = q.green;
    assign dac_blue_o         = q.blue;
    assign sleep_o            = q.mode[CMD_SLEEP_BIT];
    assign clock_inhibit_o    = q.mode[CMD_INHIBIT_BIT];
    assign sync_enable_o      = q.mode[CMD_SYNC_LSB +: 3];
endmodule

// File: rtl/php_pkg.sv
// constants shared by the palette host port and its testbench
// assumes one clock domain: the pixel clock clk_i
package php_pkg;

    // ----------------------------------------
    // register select codes
    // ----------------------------------------
    localparam logic [2:0] SEL_WRITE_INDEX = 3'h0;
    localparam logic [2:0] SEL_COLOUR      = 3'h1;
    localparam logic [2:0] SEL_MASK        = 3'h2;
    localparam logic [2:0] SEL_READ_INDEX  = 3'h3;
    localparam logic [2:0] SEL_MODE        = 3'h6;

    // ----------------------------------------
    // mode_control field positions and values
    // ----------------------------------------
    localparam int         CMD_DIRECT_BIT  = 7;
    localparam int         CMD_FMT_LSB     = 5;
    localparam int         CMD_SYNC_LSB    = 2;
    localparam int         CMD_INHIBIT_BIT = 1;
    localparam int         CMD_SLEEP_BIT   = 0;
    localparam logic [7:0] CMD_RESET       = 8'h00;
    localparam logic [1:0] FMT_15          = 2'h0;
    localparam logic [1:0] FMT_16          = 2'h1;
    localparam logic [1:0] FMT_24          = 2'h2;

    // ----------------------------------------
    // other reset values and counts
    // ----------------------------------------
    localparam logic [7:0] MASK_RESET      = 8'hFF;
    localparam logic [7:0] INDEX_RESET     = 8'h00;
    localparam logic [1:0] KEY_LAST        = 2'h3;
    localparam logic [1:0] BYTE_LAST       = 2'h2;
    localparam int         COLOUR_W        = 18;
    localparam int         FIELD_W         = 6;

    // ----------------------------------------
    // direct colour byte phase
    // ----------------------------------------
    typedef enum logic [1:0] {
        PH_FIRST  = 2'b00,
        PH_SECOND = 2'b01,
        PH_THIRD  = 2'b10
    } php_phase_type;

endpackage

// File: rtl/php_colour_table.sv
// single port colour table memory, registered read data
// assumes the caller serialises host and video use of the port
`timescale 1ns/10ps
module php_colour_table #(
    parameter int DEPTH  = 256,
    parameter int WIDTH  = 18,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // access port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic              we_i,
    input  wire logic [WIDTH-1:0]  wdata_i,
    output logic      [WIDTH-1:0]  rdata_o
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    if (DEPTH > (1 << ADDR_W) || DEPTH < 2) begin : g_bad_depth
        $error("colour table depth does not fit the address width");
    end

    // contents are not reset: they are retained across sleep
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem_q[addr_i];
        end
    end
endmodule

// File: tb/php_host_port_checker.sv
// timing checker for the palette host port, bound to its top module
// assumes host strobes idle high and one pixel clock domain
`timescale 1ns/10ps
module php_host_port_checker (
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    input wire logic       write_strobe_n_i,
    input wire logic       read_strobe_n_i,
    input wire logic [7:0] host_data_bus_o,
    input wire logic       host_data_bus_oe_o,
    input wire logic [7:0] dac_red_o,
    input wire logic [7:0] dac_green_o,
    input wire logic [7:0] dac_blue_o,
    input wire logic       sleep_o,
    input wire logic       clock_inhibit_o,
    input wire logic [2:0] sync_enable_o
);
    logic       wr_q;
    logic [3:0] wr_age_q;

    // age since the last write strobe rise, saturating so idle time never wraps
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q     <= 1'b1;
            wr_age_q <= 4'hF;
        end else begin
            wr_q <= write_strobe_n_i;
            if (write_strobe_n_i && !wr_q) begin
                wr_age_q <= 4'h0;
            end else if (wr_age_q != 4'hF) begin
                wr_age_q <= wr_age_q + 4'h1;
            end
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_read_drives_bus: assert property ($fell(read_strobe_n_i) |-> ##[2:6] host_data_bus_oe_o)
        else $error("bus not driven after read strobe fell");
    a_read_release_bus: assert property ($rose(read_strobe_n_i) |-> ##[2:6] !host_data_bus_oe_o)
        else $error("bus not released after read strobe rose");
    a_idle_bus_quiet: assert property (read_strobe_n_i [*8] |-> !host_data_bus_oe_o)
        else $error("bus driven without a read");
    a_release_after_rise: assert property ($fell(host_data_bus_oe_o) |-> $past(read_strobe_n_i, 3))
        else $error("bus released before read strobe rose");
    a_read_data_holds: assert property (host_data_bus_oe_o && $past(host_data_bus_oe_o)
        |-> $stable(host_data_bus_o))
        else $error("read data changed while driven");
    a_data_with_enable: assert property ($changed(host_data_bus_o) |-> $rose(host_data_bus_oe_o))
        else $error("read data changed outside a read");
    a_mode_after_write: assert property ($changed({sleep_o, clock_inhibit_o, sync_enable_o})
        |-> wr_age_q inside {[4'h1:4'h6]})
        else $error("mode outputs changed without a write");
    a_inhibit_freezes: assert property (clock_inhibit_o && $past(clock_inhibit_o)
        |-> $stable({dac_red_o, dac_green_o, dac_blue_o}))
        else $error("pixel path moved while clock inhibited");

    c_read: cover property ($rose(host_data_bus_oe_o));
    c_deep_sleep: cover property (clock_inhibit_o && sleep_o);
    c_pixel: cover property ($changed(dac_red_o));
endmodule

bind php_host_port php_host_port_checker i_php_host_port_checker (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .write_strobe_n_i(write_strobe_n_i),
    .read_strobe_n_i(read_strobe_n_i), .host_data_bus_o(host_data_bus_o),
    .host_data_bus_oe_o(host_data_bus_oe_o), .dac_red_o(dac_red_o),
    .dac_green_o(dac_green_o), .dac_blue_o(dac_blue_o), .sleep_o(sleep_o),
    .clock_inhibit_o(clock_inhibit_o), .sync_enable_o(sync_enable_o)
);

// File: tb/php_host_model.sv
// host processor model driving the palette host port strobes
// assumes pull-ups on every data line, as a released bus floats high
`timescale 1ns/10ps
module php_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] host_data_bus_o,
    input  wire logic       host_data_bus_oe_o,
    output logic      [2:0] register_select_o,
    output logic            write_strobe_n_o,
    output logic            read_strobe_n_o,
    output logic      [7:0] bus_level_o
);
    logic       drv;
    logic [7:0] dat;

    assign bus_level_o = host_data_bus_oe_o ? host_data_bus_o : (drv ? dat : 8'hFF);

    initial begin
        register_select_o = 3'h0;
        write_strobe_n_o  = 1'b1;
        read_strobe_n_o   = 1'b1;
        drv               = 1'b0;
        dat               = 8'h00;
    end

    // select set up four clocks ahead, data held well past the rising strobe
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        @(negedge clk_i);
        register_select_o = sel;
        dat = d;
        drv = 1'b1;
        repeat (4) @(negedge clk_i);
        write_strobe_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        write_strobe_n_o = 1'b1;
        repeat (5) @(negedge clk_i);
        drv = 1'b0;
    endtask

    task automatic rd(input logic [2:0] sel, output logic [7:0] d);
        @(negedge clk_i);
        register_select_o = sel;
        repeat (4) @(negedge clk_i);
        read_strobe_n_o = 1'b0;
        repeat (7) @(negedge clk_i);
        d = bus_level_o;
        read_strobe_n_o = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask
endmodule

// File: tb/test_php_host_port.sv
// self-checking bench for the palette host port
// assumes the host model owns strobes and the resolved data bus
`timescale 1ns/10ps
module test_php_host_port;
    import php_pkg::*;
    localparam logic [7:0] ID_TB = 8'hC3; // arbitrary identification value
    logic       clk_i, arst_n_i, wr_n, rd_n, run, oe, sleep, inhibit, watch;
    logic       blank_n = 1'b0;
    logic       glitch  = 1'b0;
    logic [2:0] sel, sync_en;
    logic [7:0] dq_in, dq_o, red, green, blue, got;
    logic [7:0] pix = 8'h00;
    logic [23:0] dac_ref;
    logic [7:0] seq [3];
    logic [7:0] col [6] = '{8'h2A, 8'h15, 8'h3F, 8'h01, 8'h02, 8'h03};
    int         ph, nph, errors, checked;

    php_host_port #(.ID_VALUE(ID_TB)) i_php_host_port (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .register_select_i(sel),
        .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .host_data_bus_i(dq_in),
        .host_data_bus_o(dq_o), .host_data_bus_oe_o(oe), .pixel_input_bus_i(pix),
        .blank_n_i(blank_n), .dac_red_o(red), .dac_green_o(green), .dac_blue_o(blue),
        .sleep_o(sleep), .clock_inhibit_o(inhibit), .sync_enable_o(sync_en)
    );
    php_host_model i_host (
        .clk_i(clk_i), .host_data_bus_o(dq_o), .host_data_bus_oe_o(oe),
        .register_select_o(sel), .write_strobe_n_o(wr_n), .read_strobe_n_o(rd_n),
        .bus_level_o(dq_in)
    );

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // pixel source: phase restarts while blanked, as direct colour needs
    always @(negedge clk_i) begin
        if (!run) begin
            blank_n <= 1'b0;
            ph      <= 0;
        end else begin
            blank_n <= 1'b1;
            pix     <= seq[ph];
            ph      <= (ph + 1 == nph) ? 0 : ph + 1;
        end
    end

    // sampled away from the launching edge so the DAC outputs have settled
    always @(negedge clk_i) begin
        if (watch && {red, green, blue} !== dac_ref) begin
            glitch <= 1'b1;
        end
    end

    function automatic logic [23:0] tbl(input int i);
        return {col[3*i][5:0], 2'h0, col[3*i+1][5:0], 2'h0, col[3*i+2][5:0], 2'h0};
    endfunction

    function automatic logic [23:0] dexp(input logic [1:0] f);
        logic [7:0] b0, b1;
        b0 = seq[0];
        b1 = seq[1];
        if (f == FMT_15) return {b1[6:2], 3'h0, b1[1:0], b0[7:5], 3'h0, b0[4:0], 3'h0};
        if (f == FMT_16) return {b1[7:3], 3'h0, b1[2:0], b0[7:5], 2'h0, b0[4:0], 3'h0};
        return {seq[2], b1, b0};
    endfunction

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] act);
        checked++;
        if (act !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, act);
        end
    endtask

    task automatic rchk(input string name, input logic [2:0] s, input logic [7:0] exp);
        i_host.rd(s, got);
        chk(name, {16'h0000, exp}, {16'h0000, got});
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        $display("[FAIL] watchdog expected done seen hang");
        close_out();
    end

    initial begin
        arst_n_i = 1'b0;
        run = 1'b0;
        nph = 1;
        seq = '{8'h01, 8'h00, 8'h00};
        {watch, errors, checked} = '0;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i) arst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rchk("index reset", SEL_WRITE_INDEX, INDEX_RESET);
        rchk("mode reset", SEL_MODE, CMD_RESET);
        rchk("unmapped", 3'h5, 8'h00);
        rchk("mask reset", SEL_MASK, MASK_RESET);
        i_host.wr(SEL_WRITE_INDEX, 8'h00);
        for (int i = 0; i < 6; i++) i_host.wr(SEL_COLOUR, col[i] | 8'hC0);
        rchk("index after load", SEL_WRITE_INDEX, 8'h02);
        i_host.wr(SEL_READ_INDEX, 8'h00);
        for (int i = 0; i < 6; i++) rchk("colour read", SEL_COLOUR, col[i]);
        rchk("index after read", SEL_READ_INDEX, 8'h03);
        run = 1'b1;
        repeat (8) @(negedge clk_i);
        chk("table pixel", tbl(1), {red, green, blue});
        // host traffic during display must not disturb the picture
        dac_ref = {red, green, blue};
        watch = 1'b1;
        i_host.wr(SEL_READ_INDEX, 8'h00);
        for (int i = 0; i < 3; i++) rchk("colour reread", SEL_COLOUR, col[i]);
        i_host.wr(SEL_MASK, 8'hFF);
        watch = 1'b0;
        chk("repeat pixel", 24'h000000, {23'h000000, glitch});
        seq[0] = 8'h31;
        i_host.wr(SEL_MASK, 8'h0F);
        rchk("mask", SEL_MASK, 8'h0F);
        chk("masked pixel", tbl(1), {red, green, blue});
        i_host.wr(SEL_MASK, 8'h00);
        repeat (8) @(negedge clk_i);
        chk("zero mask", tbl(0), {red, green, blue});
        i_host.wr(SEL_MASK, 8'hFF);
        for (int i = 0; i < 2; i++) rchk("key mask", SEL_MASK, 8'hFF);
        rchk("key break", SEL_WRITE_INDEX, 8'h02);
        for (int i = 0; i < 3; i++) rchk("key restart", SEL_MASK, 8'hFF);
        rchk("id", SEL_MASK, ID_TB);
        rchk("unlocked mode", SEL_MASK, CMD_RESET);
        rchk("still unlocked", SEL_MASK, CMD_RESET);
        i_host.wr(SEL_MASK, CMD_RESET | 8'h10);
        chk("sync order", 24'h000004, {21'h000000, sync_en});
        rchk("relocked", SEL_MASK, 8'hFF);
        rchk("mode direct", SEL_MODE, 8'h10);
        seq = '{8'hB5, 8'h5A, 8'h3C};
        for (int f = 0; f < 4; f++) begin
            run = 1'b0;
            i_host.wr(SEL_MODE, {1'b1, f[1:0], 5'h10});
            nph = (f >= 2) ? 3 : 2;
            repeat (4) @(negedge clk_i);
            run = 1'b1;
            repeat (16) @(negedge clk_i);
            chk("direct colour", dexp(f[1:0]), {red, green, blue});
        end
        run = 1'b0;
        i_host.wr(SEL_MODE, 8'h03);
        chk("sleep bits", 24'h000003, {22'h000000, inhibit, sleep});
        i_host.wr(SEL_MASK, 8'h55);
        i_host.wr(SEL_WRITE_INDEX, 8'h00);
        for (int i = 0; i < 3; i++) i_host.wr(SEL_COLOUR, 8'h00);
        rchk("mask hidden", SEL_MASK, 8'h00);
        rchk("mode reachable", SEL_MODE, 8'h03);
        i_host.wr(SEL_MODE, CMD_RESET);
        rchk("mask kept", SEL_MASK, 8'hFF);
        rchk("index kept", SEL_WRITE_INDEX, 8'h02);
        i_host.wr(SEL_READ_INDEX, 8'h00);
        for (int i = 0; i < 3; i++) rchk("table kept", SEL_COLOUR, col[i]);
        close_out();
    end
endmodule
